/* hdl/cbl_pkg.sv */
package cbl_pkg;

  // ==========================================================================
  // Opcode fields.
  localparam logic [3:0] CBL_PREFIX_BRANCH = 4'hE;
  localparam logic [3:0] CBL_SEL_ZERO = 4'h0;
  localparam logic [3:0] CBL_SEL_NOT_ZERO = 4'h1;
  localparam logic [3:0] CBL_SEL_CARRY = 4'h2;
  localparam logic [3:0] CBL_SEL_NO_CARRY = 4'h3;
  localparam logic [3:0] CBL_SEL_OVERFLOW = 4'h4;
  localparam logic [3:0] CBL_SEL_NO_OVERFLOW = 4'h5;
  localparam logic [3:0] CBL_SEL_NEGATIVE = 4'h6;
  localparam logic [3:0] CBL_SEL_NOT_NEGATIVE = 4'h7;
  localparam logic [7:0] CBL_OP_AND_LITERAL = 8'h0B;
  localparam logic [5:0] CBL_OP_AND_FILE = 6'h05;
  localparam logic [3:0] CBL_OP_CLEAR_BIT = 4'h9;

  // ==========================================================================
  // Status flag positions and reset values.
  localparam int CBL_FLAG_C = 0;
  localparam int CBL_FLAG_Z = 2;
  localparam int CBL_FLAG_OV = 3;
  localparam int CBL_FLAG_N = 4;
  localparam int CBL_PC_W = 21;
  localparam logic [20:0] CBL_PC_RESET = 21'h000000;
  localparam logic [20:0] CBL_PC_STEP = 21'h000002;
  localparam logic [7:0] CBL_BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {CBL_KIND_NONE, CBL_KIND_BRANCH, CBL_KIND_LOGIC} cbl_kind_e;

endpackage : cbl_pkg

/* hdl/cbl_dec_if.sv */
`timescale 1ns/1ps
interface cbl_dec_if;
  import cbl_pkg::*;
  logic is_branch;
  logic take;
  logic is_and_lit;
  logic is_and_file;
  logic is_clr_bit;
  modport dec (output is_branch, output take, output is_and_lit, output is_and_file, output is_clr_bit);
  modport core (input is_branch, input take, input is_and_lit, input is_and_file, input is_clr_bit);
endinterface : cbl_dec_if

/* hdl/cbl_decode.sv */
`timescale 1ns/1ps
module cbl_decode (
  // Instruction and flags.
  input wire logic [15:0] instr,
  input wire logic [7:0] status,
  // Decoded controls.
  cbl_dec_if.dec dec
);
  import cbl_pkg::*;

  // ==========================================================================
  // Branch condition select; low bit of the selector inverts the tested flag.
  wire logic prefix_ok = (instr[15:12] == CBL_PREFIX_BRANCH) && (instr[11] == 1'b0);
  wire logic [1:0] flag_pick = instr[10:9];
  wire logic flag_val = (flag_pick == 2'b00) ? status[CBL_FLAG_Z] :
                        (flag_pick == 2'b01) ? status[CBL_FLAG_C] :
                        (flag_pick == 2'b10) ? status[CBL_FLAG_OV] : status[CBL_FLAG_N];
  assign dec.is_branch = prefix_ok;
  assign dec.take = prefix_ok && (flag_val ^ instr[8]);
  assign dec.is_and_lit = (instr[15:8] == CBL_OP_AND_LITERAL);
  assign dec.is_and_file = (instr[15:10] == CBL_OP_AND_FILE);
  assign dec.is_clr_bit = (instr[15:12] == CBL_OP_CLEAR_BIT);
endmodule : cbl_decode

/* hdl/cbl_exec.sv */
`timescale 1ns/1ps
// What this block does
// - Carry branch (E2) is taken only when carry is one.
// - No-carry branch (E3) is taken only when carry is zero.
// - Negative branch (E6) is taken only when negative is one.
// - No-overflow branch (E5) is taken only when overflow is zero.
// - Taken branch: PC plus two plus twice signed offset, two cycles; else one.
module cbl_exec (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Instruction issue.
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [7:0] status_in,
  input wire logic [7:0] work_in,
  input wire logic [7:0] file_in,
  // Results.
  output logic [cbl_pkg::CBL_PC_W-1:0] pc_q,
  output logic flush_q,
  output logic busy_q,
  output logic [7:0] work_q,
  output logic [7:0] file_out_q,
  output logic file_we_q,
  output logic [7:0] status_q
);
  import cbl_pkg::*;

  cbl_dec_if dif ();

  // ==========================================================================
  // Decoder.
  cbl_decode u_dec (
    .instr(instr),
    .status(status_in),
    .dec(dif.dec)
  );

  // ==========================================================================
  // Execute datapath.
  wire logic issue = instr_valid && !busy_q;
  wire logic [CBL_PC_W-1:0] pc_inc = pc_q + CBL_PC_STEP;
  wire logic [CBL_PC_W-1:0] offs2 = {{(CBL_PC_W-9){instr[7]}}, instr[7:0], 1'b0};
  wire logic [CBL_PC_W-1:0] pc_target = pc_inc + offs2;
  wire logic [7:0] and_src = dif.is_and_lit ? instr[7:0] : file_in;
  wire logic [7:0] and_res = work_in & and_src;
  wire logic [7:0] bit_mask = ~(8'h01 << instr[11:9]);
  wire logic [7:0] clr_res = file_in & bit_mask;
  wire logic logic_op = dif.is_and_lit || dif.is_and_file;
  wire logic to_work = dif.is_and_lit || (dif.is_and_file && !instr[9]);
  wire logic to_file = (dif.is_and_file && instr[9]) || dif.is_clr_bit;
  wire logic [7:0] file_res = dif.is_clr_bit ? clr_res : and_res;
  wire logic [7:0] status_new = {status_in[7:5], and_res[7], status_in[3], (and_res == CBL_BYTE_ZERO),
                                 status_in[1:0]};

  // Program counter and taken-branch bubble; the bubble cycle executes nothing.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= CBL_PC_RESET;
      busy_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      pc_q <= (issue && dif.take) ? pc_target : (issue ? pc_inc : pc_q);
      busy_q <= issue && dif.take;
      flush_q <= issue && dif.take;
    end
  end

  // Logic results; flags change only for the AND forms.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      work_q <= CBL_BYTE_ZERO;
      file_out_q <= CBL_BYTE_ZERO;
      file_we_q <= 1'b0;
      status_q <= CBL_BYTE_ZERO;
    end else begin
      work_q <= (issue && to_work) ? and_res : work_in;
      file_out_q <= file_res;
      file_we_q <= issue && to_file;
      status_q <= (issue && logic_op) ? status_new : status_in;
    end
  end

  // ==========================================================================
  // Checks.
  sequence s_taken;
    issue && dif.take;
  endsequence

  AST_TAKEN_TARGET: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_taken |=> pc_q == $past(pc_target)) else $error("taken branch target wrong");
  AST_TAKEN_BUBBLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_taken |=> busy_q ##1 !busy_q) else $error("taken branch not two cycles");
  AST_NOT_TAKEN: assert property (@(posedge core_clk) disable iff (!rst_n)
    (issue && dif.is_branch && !dif.take) |=> !busy_q && pc_q == $past(pc_inc)) else $error("untaken branch");
  AST_CARRY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (instr[15:8] == 8'hE2) |-> dif.take == status_in[CBL_FLAG_C]) else $error("carry branch");
  AST_NO_CARRY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (instr[15:8] == 8'hE3) |-> dif.take == !status_in[CBL_FLAG_C]) else $error("no carry branch");
  AST_NEG: assert property (@(posedge core_clk) disable iff (!rst_n)
    (instr[15:8] == 8'hE6) |-> dif.take == status_in[CBL_FLAG_N]) else $error("negative branch");
  AST_NO_OV: assert property (@(posedge core_clk) disable iff (!rst_n)
    (instr[15:8] == 8'hE5) |-> dif.take == !status_in[CBL_FLAG_OV]) else $error("no overflow branch");
  AST_NOT_NZ: assert property (@(posedge core_clk) disable iff (!rst_n)
    (instr[15:8] == 8'hE7 || instr[15:8] == 8'hE1) |->
    dif.take == !(instr[9] ? status_in[CBL_FLAG_N] : status_in[CBL_FLAG_Z])) else $error("not-flag branch");

  // ==========================================================================
  // Checks on accept, hold and bubble timing.
  // A taken branch costs exactly one extra cycle. That cycle must never move
  // the program counter, even when the fetch side keeps offering a new word,
  // because the word offered then is the one the core is about to discard.
  sequence s_bubble;
    busy_q;
  endsequence

  sequence s_untaken;
    issue && !dif.take;
  endsequence

  sequence s_idle;
    !instr_valid && !busy_q;
  endsequence

  // The bubble cycle holds the program counter.
  AST_BUBBLE_HOLDS_PC: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_bubble |=> pc_q == $past(pc_q))
    else $error("program counter moved in bubble");

  // The bubble never starts a second bubble or a file write.
  AST_BUBBLE_REFUSES: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_bubble |=> !busy_q && !file_we_q)
    else $error("word accepted in bubble");

  // Every accepted word that does not branch advances by one instruction.
  AST_UNTAKEN_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_untaken |=> pc_q == $past(pc_q) + CBL_PC_STEP)
    else $error("program counter step wrong");

  // With nothing offered the program counter stands still.
  AST_IDLE_HOLDS_PC: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_idle |=> pc_q == $past(pc_q) && !flush_q)
    else $error("program counter moved while idle");

  // The flush pulse lasts one cycle and always rides with the bubble.
  AST_FLUSH_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
    flush_q |-> busy_q ##1 !flush_q)
    else $error("flush pulse wrong length");

  // A word with bit 11 set behind the branch prefix is not a conditional branch,
  // so it must never redirect the flow through this path.
  AST_PREFIX_BIT11: assert property (@(posedge core_clk) disable iff (!rst_n)
    (instr[15:11] == 5'h1D) |-> !dif.is_branch && !dif.take)
    else $error("bit 11 word decoded as branch");

  // ==========================================================================
  // Checks on the AND and bit-clear forms.
  // These results are valid only in the cycle after the accept edge, so each
  // check compares against the inputs as they were sampled at that edge. The
  // write strobe is a single pulse; a consumer that misses it loses the write.
  sequence s_and_lit;
    issue && dif.is_and_lit;
  endsequence

  sequence s_and_to_work;
    issue && dif.is_and_file && !instr[9];
  endsequence

  sequence s_and_to_file;
    issue && dif.is_and_file && instr[9];
  endsequence

  sequence s_clr_bit;
    issue && dif.is_clr_bit;
  endsequence

  sequence s_branch;
    issue && dif.is_branch;
  endsequence

  // The literal AND lands in the working register and writes no file.
  AST_AND_LIT_WORK: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_and_lit |=> work_q == ($past(work_in) & $past(instr[7:0])) && !file_we_q)
    else $error("literal and result wrong");

  // Its negative and zero flags follow the result; carry and overflow pass through.
  AST_AND_LIT_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_and_lit |=> status_q[CBL_FLAG_N] == work_q[7] && status_q[CBL_FLAG_Z] == (work_q == CBL_BYTE_ZERO) &&
    status_q[CBL_FLAG_C] == $past(status_in[CBL_FLAG_C]) && status_q[CBL_FLAG_OV] == $past(status_in[CBL_FLAG_OV]))
    else $error("literal and flags wrong");

  // The file AND with the working destination writes no file.
  AST_AND_FILE_WORK: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_and_to_work |=> work_q == ($past(work_in) & $past(file_in)) && !file_we_q)
    else $error("file and to work wrong");

  // The file AND with the file destination leaves the working register alone.
  AST_AND_FILE_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_and_to_file |=> file_we_q && file_out_q == ($past(work_in) & $past(file_in)) &&
    work_q == $past(work_in))
    else $error("file and to file wrong");

  // Flags of the file AND follow the value that is written back.
  AST_AND_FILE_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_and_to_file |=> status_q[CBL_FLAG_Z] == (file_out_q == CBL_BYTE_ZERO) &&
    status_q[CBL_FLAG_N] == file_out_q[7])
    else $error("file and flags wrong");

  // Bit clear zeroes the chosen bit and keeps every other bit.
  AST_CLR_BIT_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_clr_bit |=> file_we_q && file_out_q[$past(instr[11:9])] == 1'b0 &&
    (file_out_q | (8'h01 << $past(instr[11:9]))) == ($past(file_in) | (8'h01 << $past(instr[11:9]))))
    else $error("bit clear result wrong");

  // Bit clear touches neither the flags nor the working register.
  AST_CLR_BIT_KEEPS: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_clr_bit |=> status_q == $past(status_in) && work_q == $past(work_in))
    else $error("bit clear changed flags");

  // Branches affect no flag, no working register and no file.
  AST_BRANCH_KEEPS: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_branch |=> status_q == $past(status_in) && work_q == $past(work_in) && !file_we_q)
    else $error("branch changed data state");

  // A file write strobe only ever follows an accepted file-writing word.
  AST_WRITE_CAUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
    file_we_q |-> $past(issue && (dif.is_clr_bit || (dif.is_and_file && instr[9]))))
    else $error("file write without cause");
endmodule : cbl_exec

/* testbench/test_cond_branch_and_logic_exec.sv */
`timescale 1ns/1ps
module test_cond_branch_and_logic_exec;
  import cbl_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals.
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [7:0] status_in = 8'h00, work_in = 8'hA3, file_in = 8'h5C;
  logic [CBL_PC_W-1:0] pc_q, exp_pc;
  logic flush_q, busy_q, file_we_q;
  logic [7:0] work_q, file_out_q, status_q;
  int err_count = 0;
  int comparisons = 0;

  cbl_exec uut (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .status_in(status_in), .work_in(work_in), .file_in(file_in), .pc_q(pc_q), .flush_q(flush_q),
    .busy_q(busy_q), .work_q(work_q), .file_out_q(file_out_q), .file_we_q(file_we_q), .status_q(status_q));

  // The 25 ns clock.
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // One branch; a taken one leaves a bubble, so a third edge lets it pass.
  task automatic step(input logic [3:0] sel, input logic [7:0] st, input logic [7:0] off, input logic tk);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr <= {CBL_PREFIX_BRANCH, sel, off};
    status_in <= st;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1 exp_pc = exp_pc + 21'h000002 + (tk ? {{12{off[7]}}, off, 1'b0} : 21'h000000);
    check(pc_q, exp_pc);
    check({busy_q, flush_q}, {tk, tk});
    @(posedge core_clk);
  endtask : step

  // ==========================================================================
  // Scenarios; flags sit at C=bit0, Z=bit2, OV=bit3, N=bit4.
  task automatic test_carry;
    step(CBL_SEL_CARRY, 8'h01, 8'h05, 1'b1);
    step(CBL_SEL_CARRY, 8'hFE, 8'h05, 1'b0);
    step(CBL_SEL_NO_CARRY, 8'h00, 8'hF0, 1'b1);
    step(CBL_SEL_NO_CARRY, 8'h01, 8'hF0, 1'b0);
  endtask : test_carry

  task automatic test_neg_ovf;
    step(CBL_SEL_NEGATIVE, 8'h10, 8'h11, 1'b1);
    step(CBL_SEL_NEGATIVE, 8'hEF, 8'h11, 1'b0);
    step(CBL_SEL_NO_OVERFLOW, 8'hF7, 8'h22, 1'b1);
    step(CBL_SEL_NO_OVERFLOW, 8'h08, 8'h22, 1'b0);
  endtask : test_neg_ovf

  task automatic test_offset_limits;
    step(CBL_SEL_CARRY, 8'h01, 8'h80, 1'b1);
    step(CBL_SEL_CARRY, 8'h01, 8'h7F, 1'b1);
  endtask : test_offset_limits

  task automatic test_not_flags;
    step(CBL_SEL_NOT_NEGATIVE, 8'hEF, 8'h09, 1'b1);
    step(CBL_SEL_NOT_NEGATIVE, 8'h10, 8'h09, 1'b0);
    step(CBL_SEL_NOT_ZERO, 8'hFB, 8'hFF, 1'b1);
    step(CBL_SEL_NOT_ZERO, 8'h04, 8'hFF, 1'b0);
  endtask : test_not_flags

  // A word offered during the bubble must leave no trace.
  task automatic test_bubble_refused;
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr <= {CBL_PREFIX_BRANCH, CBL_SEL_CARRY, 8'h03};
    status_in <= 8'h01;
    @(posedge core_clk);
    instr <= {CBL_PREFIX_BRANCH, CBL_SEL_CARRY, 8'h40};
    #1 exp_pc = exp_pc + 21'h000008;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1 check({pc_q, busy_q}, {exp_pc, 1'b0});
    @(posedge core_clk);
  endtask : test_bubble_refused

  // AND and bit-clear forms, back to back; each result shows one edge after its accept.
  task automatic test_logic;
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr <= {CBL_OP_AND_LITERAL, 8'h5F};
    status_in <= 8'h14;
    file_in <= 8'hF0;
    @(posedge core_clk);
    instr <= {CBL_OP_AND_FILE, 2'b10, 8'h00};
    #1 check({work_q, status_q, file_we_q}, {8'h03, 8'h00, 1'b0});
    @(posedge core_clk);
    instr <= {CBL_OP_CLEAR_BIT, 3'h5, 9'h000};
    #1 check({file_out_q, file_we_q, work_q, status_q}, {8'hA0, 1'b1, 8'hA3, 8'h10});
    @(posedge core_clk);
    instr <= {CBL_OP_AND_FILE, 2'b00, 8'h00};
    #1 check({file_out_q, file_we_q, work_q, status_q}, {8'hD0, 1'b1, 8'hA3, 8'h14});
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1 exp_pc = exp_pc + 21'h000008;
    check({work_q, file_we_q, status_q}, {8'hA0, 1'b0, 8'h10});
    check(pc_q, exp_pc);
  endtask : test_logic

  // Reset in mid-run clears every output; the first branch after it starts from zero.
  task automatic test_reset_mid;
    @(posedge core_clk);
    rst_n <= 1'b0;
    #1 check({pc_q, busy_q, flush_q, file_we_q}, 32'h00000000);
    check({work_q, file_out_q, status_q}, 32'h00000000);
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    exp_pc = CBL_PC_RESET;
    step(CBL_SEL_CARRY, 8'h01, 8'h02, 1'b1);
  endtask : test_reset_mid

  // ==========================================================================
  // Main sequence, with a watchdog far beyond the roughly sixty cycles needed.
  initial begin
    exp_pc = CBL_PC_RESET;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    test_carry();
    test_neg_ovf();
    test_offset_limits();
    test_not_flags();
    test_bubble_refused();
    test_logic();
    test_reset_mid();
    tally_and_finish();
  end

  initial begin
    #50000;
    err_count++;
    tally_and_finish();
  end
endmodule : test_cond_branch_and_logic_exec
